// ===== verilog/interrupt_event_queue.sv
// Purpose: Interrupt queue, merging and handler dispatch with AHB-Lite registers
// Assumes: Counter overflow inputs are one-cycle pulses on sys_clk
// Notes:   Zero wait state slave, response always OKAY
`timescale 1ns/10ps
// Overview of operation
// RULE1: On enable the queue drains; with the handler bit set, one handler start per entry with its flags shown.
// RULE2: Edges arriving while the reaction timer runs merge into the pending entry.
// RULE3: With eight entries queued, new causes are ORed into the eighth entry.
// RULE4: A repeat cause on an already set flag is absorbed and lost.
// RULE5: Reaction time runs from first event and is 0.6 ms with no extras.
// RULE6: Extras add 0.5 ms, 0.2 ms and 8.0 ms to the reaction time.
// RULE7: Sources must hold each pulse at least the reaction time.
// RULE8: Lower priority sources wait behind higher ones, adding delay.
// RULE9: Channels 0 to 3 set cause bits 4 to 7 by OR, even without a handler.
// RULE10: With interrupts disabled, events are still detected and queued.
// RULE11: Simultaneous causes dispatch counter B, then channels, then counter A.
// RULE12: A running handler is never preempted; entries go out in order.
// RULE13: A queue full status decides between new entry and merge into the last.
module interrupt_event_queue #(
  parameter int unsigned BASE_CYC   = iq_pkg::BASE_CYC,
  parameter int unsigned FB_CYC     = iq_pkg::FB_CYC,
  parameter int unsigned CLKPAR_CYC = iq_pkg::CLKPAR_CYC,
  parameter int unsigned NET_CYC    = iq_pkg::NET_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic [3:0]  irq_pin,
  input  wire logic        ctr_a_ovf,
  input  wire logic        ctr_b_ovf,
  input  wire logic        handler_done,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             handler_start,
  output logic      [7:0]  handler_cause,
  output logic             handler_busy,
  output logic      [7:0]  interrupt_cause_byte,
  output logic             queue_full
);

  localparam int TW = iq_pkg::TIMER_W;

  typedef struct packed {
    logic                                en;
    logic                                hnd;
    logic                                fb;
    logic                                clkp;
    logic                                net;
    logic [7:0]                          cause;
    logic [iq_pkg::QDEPTH-1:0][7:0]      q;
    logic [2:0]                          head;
    logic [3:0]                          count;
    logic                                full;
    logic [7:0]                          pend;
    logic [TW-1:0]                       timer;
    iq_pkg::phase_t                      phase;
    logic                                busy;
    logic                                start;
    logic [7:0]                          out;
    logic                                wr_act;
    logic [7:0]                          addr;
    logic [31:0]                         rdata;
    logic                                ready;
    logic                                resp;
  } state_t;

  localparam state_t ST_RST = '{
    phase:   iq_pkg::PH_IDLE,
    cause:   iq_pkg::CAUSE_RST,
    ready:   1'b1,
    default: '0
  };

  state_t        st;
  state_t        nx;
  logic [7:0]    new_bits;
  logic [7:0]    push_val;
  logic [7:0]    head_val;
  logic [7:0]    clr;
  logic [7:0]    cause_set;
  logic [TW-1:0] total;
  logic [2:0]    tail;
  logic [2:0]    last;
  logic          push;
  logic          pop;
  logic          grow;

  edge_if ev ();

  edge_sync u_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .ce      (ce),
    .irq_pin (irq_pin),
    .edges   (ev)
  );

  always_comb begin
    nx        = st;
    push_val  = '0;
    head_val  = '0;
    clr       = '0;
    cause_set = '0;
    push      = 1'b0;
    pop       = 1'b0;
    nx.start  = 1'b0;
    nx.ready  = 1'b1;
    nx.resp   = 1'b0;
    new_bits  = {ev.edge_det, 2'b00, ctr_b_ovf, ctr_a_ovf}; // [RULE9]
    total     = TW'(BASE_CYC + (st.fb ? FB_CYC : 0) + (st.clkp ? CLKPAR_CYC : 0)
                    + (st.net ? NET_CYC : 0)); // [RULE5] [RULE6]
    tail      = st.head + st.count[2:0];
    last      = tail - 3'h1;

    // Bus address phase
    nx.wr_act = 1'b0;
    if (hsel && htrans[1] && hready) begin
      nx.wr_act = hwrite;
      nx.addr   = haddr[7:0];
      case (haddr[7:0])
        iq_pkg::OFS_CTRL:   nx.rdata = {27'h0, st.net, st.clkp, st.fb, st.hnd, st.en};
        iq_pkg::OFS_CAUSE:  nx.rdata = {24'h0, st.cause};
        iq_pkg::OFS_STATUS: nx.rdata = {25'h0, st.pend != 8'h00, st.busy, st.full, st.count};
        default:            nx.rdata = 32'h0000_0000;
      endcase
    end

    // Bus data phase
    if (st.wr_act) begin
      case (st.addr)
        iq_pkg::OFS_CTRL: begin
          nx.en   = hwdata[iq_pkg::CTRL_EN_BIT];
          nx.hnd  = hwdata[iq_pkg::CTRL_HND_BIT];
          nx.fb   = hwdata[iq_pkg::CTRL_FB_BIT];
          nx.clkp = hwdata[iq_pkg::CTRL_CLK_BIT];
          nx.net  = hwdata[iq_pkg::CTRL_NET_BIT];
        end
        iq_pkg::OFS_CAUSE: clr = hwdata[7:0];
        default: ;
      endcase
    end

    // Event capture and reaction timing, independent of enable [RULE10]
    unique case (st.phase)
      iq_pkg::PH_IDLE: begin
        if (new_bits != 8'h00) begin
          nx.pend  = new_bits;
          nx.timer = total - TW'(1); // [RULE5]
          nx.phase = iq_pkg::PH_TIMING;
        end
      end
      iq_pkg::PH_TIMING: begin
        nx.pend = st.pend | new_bits; // [RULE2] [RULE4]
        if (st.timer == '0) begin
          nx.phase = iq_pkg::PH_FLUSH;
        end else begin
          nx.timer = st.timer - TW'(1);
        end
      end
      iq_pkg::PH_FLUSH: begin
        // One class per cycle in priority order [RULE11] [RULE8]
        if ((st.pend & iq_pkg::MASK_CTR_B) != 8'h00) begin
          push_val = st.pend & iq_pkg::MASK_CTR_B;
        end else if ((st.pend & iq_pkg::MASK_CH) != 8'h00) begin
          push_val = st.pend & iq_pkg::MASK_CH;
        end else begin
          push_val = st.pend & iq_pkg::MASK_CTR_A;
        end
        push    = push_val != 8'h00;
        nx.pend = (st.pend & ~push_val) | new_bits;
        if (nx.pend == 8'h00) begin
          nx.phase = iq_pkg::PH_IDLE;
        end
      end
      default: nx.phase = iq_pkg::PH_IDLE;
    endcase

    // Dispatch, only when enabled and no handler runs [RULE1] [RULE12]
    if (st.busy && handler_done) begin
      nx.busy = 1'b0;
    end
    if (st.en && !st.busy && st.count != 4'h0) begin
      pop       = 1'b1;
      head_val  = st.q[st.head];
      nx.head   = st.head + 3'h1;
      cause_set = head_val; // [RULE9]
      if (st.hnd) begin
        nx.busy  = 1'b1;
        nx.start = 1'b1;
        nx.out   = head_val; // [RULE1]
      end
    end

    // Queue write: new entry, or merge into the last when full and no entry is popped [RULE3] [RULE13]
    grow = push && !(st.full && !pop);
    if (push) begin
      if (grow) begin
        nx.q[tail] = push_val;
      end else begin
        nx.q[last] = st.q[last] | push_val; // [RULE4]
      end
    end
    if (grow && !pop) begin
      nx.count = st.count + 4'h1;
    end else if (pop && !grow) begin
      nx.count = st.count - 4'h1;
    end
    nx.full = nx.count == iq_pkg::QCOUNT_FULL; // [RULE13]

    // Software clears, hardware set wins [RULE9]
    nx.cause = (st.cause & ~clr) | cause_set;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= ST_RST;
    end else if (ce) begin
      st <= nx;
    end
  end

  assign hrdata               = st.rdata;
  assign hreadyout            = st.ready;
  assign hresp                = st.resp;
  assign handler_start        = st.start;
  assign handler_cause        = st.out;
  assign handler_busy         = st.busy;
  assign interrupt_cause_byte = st.cause;
  assign queue_full           = st.full;

  a_start_one_cycle: assert property (@(posedge sys_clk) disable iff (!resetn || !ce) // [RULE1]
    st.start |=> !st.start && st.busy)
    else $error("handler start longer than one cycle");

  a_start_has_cause: assert property (@(posedge sys_clk) disable iff (!resetn || !ce) // [RULE1]
    st.start |-> st.out != 8'h00 && (st.cause & st.out) == st.out)
    else $error("handler started without cause flags");

  a_no_preempt: assert property (@(posedge sys_clk) disable iff (!resetn || !ce) // [RULE12]
    st.busy && !handler_done |=> !st.start)
    else $error("handler preempted");

  a_disabled_holds: assert property (@(posedge sys_clk) disable iff (!resetn || !ce) // [RULE10]
    !st.en && st.count != 4'h0 |=> !st.start && st.count >= $past(st.count))
    else $error("queue drained while disabled");

  a_queue_bound: assert property (@(posedge sys_clk) disable iff (!resetn || !ce) // [RULE3]
    st.full && push && !pop |=> st.count == iq_pkg::QCOUNT_FULL)
    else $error("queue grew past eight entries");

  a_full_flag: assert property (@(posedge sys_clk) disable iff (!resetn || !ce) // [RULE13]
    $rose(st.full) |-> $past(st.count) == 4'h7)
    else $error("full flag without eighth entry");

  a_timer_load: assert property (@(posedge sys_clk) disable iff (!resetn || !ce) // [RULE6]
    st.phase == iq_pkg::PH_IDLE && new_bits != 8'h00 |=>
      st.phase == iq_pkg::PH_TIMING && st.timer == $past(total) - TW'(1))
    else $error("reaction timer loaded wrongly");

  a_timer_expire: assert property (@(posedge sys_clk) disable iff (!resetn || !ce) // [RULE5]
    st.phase == iq_pkg::PH_TIMING && st.timer == '0 |=> st.phase == iq_pkg::PH_FLUSH)
    else $error("reaction time not ended on expiry");

  a_merge_pend: assert property (@(posedge sys_clk) disable iff (!resetn || !ce) // [RULE2]
    st.phase == iq_pkg::PH_TIMING && new_bits != 8'h00 |=>
      (st.pend & $past(new_bits)) == $past(new_bits))
    else $error("edge not merged into pending entry");

  a_prio_order: assert property (@(posedge sys_clk) disable iff (!resetn || !ce) // [RULE11]
    st.phase == iq_pkg::PH_FLUSH && st.pend[1] |-> push_val == iq_pkg::MASK_CTR_B)
    else $error("counter B not queued first");

  a_cause_sticky: assert property (@(posedge sys_clk) disable iff (!resetn || !ce) // [RULE9]
    !(st.wr_act && st.addr == iq_pkg::OFS_CAUSE) |=>
      (st.cause & $past(st.cause)) == $past(st.cause))
    else $error("cause bit lost without clear");

  a_drain_enabled: assert property (@(posedge sys_clk) disable iff (!resetn || !ce) // [RULE1]
    st.en && st.hnd && !st.busy && st.count != 4'h0 |=>
      st.start && st.out == $past(st.q[st.head]))
    else $error("queued entry not dispatched");

  a_full_merge: assert property (@(posedge sys_clk) disable iff (!resetn || !ce) // [RULE3]
    st.full && push && !pop |=> st.q[$past(last)] == ($past(st.q[last]) | $past(push_val)))
    else $error("cause not merged into eighth entry");

  a_ch_wait: assert property (@(posedge sys_clk) disable iff (!resetn || !ce) // [RULE8]
    st.phase == iq_pkg::PH_FLUSH && st.pend[1] && (st.pend & iq_pkg::MASK_CH) != 8'h00 |=>
      (st.pend & iq_pkg::MASK_CH) != 8'h00)
    else $error("channel entry did not wait behind counter B");

  a_ctr_a_last: assert property (@(posedge sys_clk) disable iff (!resetn || !ce) // [RULE11]
    st.phase == iq_pkg::PH_FLUSH && (st.pend & (iq_pkg::MASK_CH | iq_pkg::MASK_CTR_B)) != 8'h00
      |-> !push_val[0])
    else $error("counter A queued ahead of higher sources");

  a_disabled_capture: assert property (@(posedge sys_clk) disable iff (!resetn || !ce) // [RULE10]
    !st.en && st.phase == iq_pkg::PH_IDLE && new_bits != 8'h00 |=>
      st.phase == iq_pkg::PH_TIMING)
    else $error("event not captured while disabled");

  a_repeat_absorbed: assert property (@(posedge sys_clk) disable iff (!resetn || !ce) // [RULE4]
    st.phase == iq_pkg::PH_TIMING && (new_bits & ~st.pend) == 8'h00 |=>
      st.pend == $past(st.pend))
    else $error("repeated cause changed pending entry");

endmodule : interrupt_event_queue

// ===== shared/iq_pkg.sv
// Purpose: Constants and types shared by the interrupt event queue design
// Assumes: 100 MHz system clock, 32-bit AHB-Lite register port
// Notes:   Reaction times are held in ns, cycle counts derive from them
package iq_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // Reaction time components, ns
  localparam int BASE_NS   = 600000;
  localparam int FB_NS     = 500000;
  localparam int CLKPAR_NS = 200000;
  localparam int NET_NS    = 8000000;

  // Reaction time components, cycles
  localparam int BASE_CYC   = (BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FB_CYC     = (FB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLKPAR_CYC = (CLKPAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NET_CYC    = (NET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int TIMER_W = 20;
  localparam int NUM_CH  = 4;
  localparam int QDEPTH  = 8;
  localparam logic [3:0] QCOUNT_FULL = 4'h8;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CAUSE  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // Control field positions
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_HND_BIT = 1;
  localparam int CTRL_FB_BIT  = 2;
  localparam int CTRL_CLK_BIT = 3;
  localparam int CTRL_NET_BIT = 4;

  // Status field positions
  localparam int STAT_FULL_BIT = 4;
  localparam int STAT_BUSY_BIT = 5;
  localparam int STAT_PEND_BIT = 6;

  // Cause byte classes
  localparam logic [7:0] MASK_CTR_A = 8'h01;
  localparam logic [7:0] MASK_CTR_B = 8'h02;
  localparam logic [7:0] MASK_CH    = 8'hF0;

  localparam logic [7:0] CAUSE_RST = 8'h00;

  typedef enum logic [1:0] {PH_IDLE, PH_TIMING, PH_FLUSH} phase_t;

endpackage : iq_pkg

// ===== shared/edge_if.sv
// Purpose: Carries detected channel edges from the synchroniser to the queue
// Assumes: One-cycle pulses per channel on sys_clk
// Notes:   Bit n is channel n
`timescale 1ns/10ps
interface edge_if;
  logic [3:0] edge_det;
  modport src (output edge_det);
  modport dst (input  edge_det);
endinterface : edge_if

// ===== verilog/edge_sync.sv
// Purpose: Three-stage input synchroniser and rising edge detector per channel
// Assumes: Pins are asynchronous to sys_clk
// Notes:   A change counts once stages two and three agree
`timescale 1ns/10ps
module edge_sync (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic [3:0] irq_pin,
  edge_if.src             edges
);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] level;
    logic [3:0] det;
  } sync_t;

  sync_t st;
  sync_t nx;
  logic [3:0] agree;

  always_comb begin
    nx       = st;
    agree    = ~(st.s2 ^ st.s3);
    nx.s1    = irq_pin;
    nx.s2    = st.s1;
    nx.s3    = st.s2;
    // Pulses shorter than the filter are never seen [RULE7]
    nx.level = (st.s3 & agree) | (st.level & ~agree);
    nx.det   = nx.level & ~st.level;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else if (ce) begin
      st <= nx;
    end
  end

  assign edges.edge_det = st.det;

endmodule : edge_sync

// ===== tb/transducer_model.sv
// Purpose: Transducer model driving the interrupt pins with held pulses
// Assumes: fire is a one-cycle request per channel on sys_clk
// Notes:   A pin returns low once its hold count has run out
`timescale 1ns/10ps
module transducer_model (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  fire,
  input  wire logic [15:0] hold,
  output logic      [3:0]  irq_pin
);
  logic [15:0] cnt [4];

  // Pulse held for the hold count
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_pin <= 4'h0;
      for (int i = 0; i < 4; i++) cnt[i] <= 16'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (fire[i]) begin
          irq_pin[i] <= 1'h1;
          cnt[i]     <= hold;
        end else if (cnt[i] != 16'h0) begin
          cnt[i] <= cnt[i] - 16'h1;
        end else begin
          irq_pin[i] <= 1'h0;
        end
      end
    end
  end
endmodule : transducer_model

// ===== tb/interrupt_event_queue_bench.sv
// Purpose: Self-checking bench for the interrupt event queue
// Assumes: Short reaction counts set by parameters
// Notes:   Bus tasks follow AHB-Lite single word transfers
`timescale 1ns/10ps
module interrupt_event_queue_bench;
  localparam int B = 20;
  logic        sys_clk, resetn, ce, ctr_a_ovf, ctr_b_ovf, handler_done, hsel, hwrite;
  logic        hreadyout, hresp, handler_start, handler_busy, queue_full;
  logic [1:0]  htrans;
  logic [3:0]  fire, irq_pin;
  logic [15:0] hold;
  logic [7:0]  handler_cause, interrupt_cause_byte;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          err_count, n_compared, n;

  transducer_model i_src (.sys_clk(sys_clk), .resetn(resetn), .fire(fire), .hold(hold),
    .irq_pin(irq_pin));

  interrupt_event_queue #(.BASE_CYC(B), .FB_CYC(10), .CLKPAR_CYC(5), .NET_CYC(30)) i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .irq_pin(irq_pin),
    .ctr_a_ovf(ctr_a_ovf), .ctr_b_ovf(ctr_b_ovf), .handler_done(handler_done),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .handler_start(handler_start), .handler_cause(handler_cause),
    .handler_busy(handler_busy), .interrupt_cause_byte(interrupt_cause_byte),
    .queue_full(queue_full));

  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
      if (k > 50) begin
        err_count++;
        report_and_stop;
      end
    end while (hreadyout !== 1'h1);
  endtask : wait_rdy

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    wait_rdy;
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
  endtask : ahb

  task automatic wait_start(input logic [7:0] c, input int lim);
    n = 0;
    do begin
      @(posedge sys_clk);
      ctr_a_ovf <= 1'h0;
      ctr_b_ovf <= 1'h0;
      fire      <= 4'h0;
      n++;
      if (n > lim) begin
        err_count++;
        report_and_stop;
      end
      #1;
    end while (handler_start !== 1'h1);
    chk("handler_cause", c, handler_cause);
    chk("handler_busy", 32'h1, handler_busy);
  endtask : wait_start

  task automatic quiet(input int cyc);
    int s;
    s = 0;
    repeat (cyc) begin
      @(posedge sys_clk);
      #1;
      if (handler_start === 1'h1) s++;
    end
    chk("extra starts", 32'h0, s);
  endtask : quiet

  task automatic done;
    @(posedge sys_clk);
    handler_done <= 1'h1;
    @(posedge sys_clk);
    handler_done <= 1'h0;
  endtask : done

  task automatic t_regs;
    chk("hreadyout", 32'h1, hreadyout);
    chk("hresp", 32'h0, hresp);
    ahb(1'h0, iq_pkg::OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    ahb(1'h1, iq_pkg::OFS_CTRL, 32'h1F);
    ahb(1'h0, iq_pkg::OFS_CTRL, 32'h0);
    chk("ctrl", 32'h1F, rd);
    ahb(1'h0, 8'h0C, 32'h0);
    chk("unmapped", 32'h0, rd);
    ahb(1'h0, iq_pkg::OFS_STATUS, 32'h0);
    chk("status", 32'h0, rd);
  endtask : t_regs

  task automatic t_react(input logic [31:0] ctl, input int t);
    ahb(1'h1, iq_pkg::OFS_CTRL, ctl);
    @(posedge sys_clk);
    ctr_b_ovf <= 1'h1;
    wait_start(8'h02, t + 10);
    chk("reaction cycles", t + 3, n);
    done;
    chk("cause output", 32'h02, interrupt_cause_byte);
    ahb(1'h0, iq_pkg::OFS_CAUSE, 32'h0);
    chk("cause byte", 32'h02, rd);
    ahb(1'h1, iq_pkg::OFS_CAUSE, 32'h02);
    ahb(1'h0, iq_pkg::OFS_CAUSE, 32'h0);
    chk("cause cleared", 32'h0, rd);
  endtask : t_react

  task automatic t_merge;
    ahb(1'h1, iq_pkg::OFS_CTRL, 32'h03);
    @(posedge sys_clk);
    fire <= 4'h2;
    @(posedge sys_clk);
    fire <= 4'h0;
    repeat (4) @(posedge sys_clk);
    fire <= 4'h4;
    wait_start(8'h60, 3 * B);
    done;
    quiet(3 * B);
    ahb(1'h1, iq_pkg::OFS_CAUSE, 32'hFF);
  endtask : t_merge

  task automatic t_prio;
    @(posedge sys_clk);
    ctr_a_ovf <= 1'h1;
    ctr_b_ovf <= 1'h1;
    fire      <= 4'h1;
    wait_start(8'h02, 3 * B);
    quiet(30);
    done;
    wait_start(8'h10, 3 * B);
    done;
    wait_start(8'h01, 3 * B);
    done;
  endtask : t_prio

  task automatic t_queue;
    ahb(1'h1, iq_pkg::OFS_CTRL, 32'h02);
    repeat (7) begin
      @(posedge sys_clk);
      ctr_a_ovf <= 1'h1;
      @(posedge sys_clk);
      ctr_a_ovf <= 1'h0;
      repeat (B + 8) @(posedge sys_clk);
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      fire <= (i == 1) ? 4'h4 : 4'h8;
      @(posedge sys_clk);
      fire <= 4'h0;
      repeat (50) @(posedge sys_clk);
    end
    chk("queue_full", 32'h1, queue_full);
    chk("busy while disabled", 32'h0, handler_busy);
    ahb(1'h1, iq_pkg::OFS_CTRL, 32'h03);
    for (int i = 0; i < 8; i++) begin
      wait_start((i < 7) ? 8'h01 : 8'hC0, 3 * B);
      done;
    end
    quiet(3 * B);
    chk("queue_full", 32'h0, queue_full);
  endtask : t_queue

  task automatic t_freeze;
    ahb(1'h1, iq_pkg::OFS_CTRL, 32'h03);
    @(posedge sys_clk);
    ctr_b_ovf <= 1'h1;
    @(posedge sys_clk);
    ctr_b_ovf <= 1'h0;
    ce        <= 1'h0;
    repeat (10) @(posedge sys_clk);
    ce <= 1'h1;
    wait_start(8'h02, B + 10);
    chk("frozen reaction cycles", B + 2, n);
    done;
    ahb(1'h1, iq_pkg::OFS_CAUSE, 32'h02);
  endtask : t_freeze

  task automatic t_nohnd;
    ahb(1'h1, iq_pkg::OFS_CAUSE, 32'hFF);
    ahb(1'h1, iq_pkg::OFS_CTRL, 32'h01);
    @(posedge sys_clk);
    ctr_a_ovf <= 1'h1;
    @(posedge sys_clk);
    ctr_a_ovf <= 1'h0;
    quiet(B + 10);
    chk("cause without handler", 32'h01, interrupt_cause_byte);
    chk("busy without handler", 32'h0, handler_busy);
  endtask : t_nohnd

  initial begin
    resetn       = 1'h0;
    ctr_a_ovf    = 1'h0;
    ctr_b_ovf    = 1'h0;
    handler_done = 1'h0;
    hsel         = 1'h0;
    hwrite       = 1'h0;
    htrans       = 2'h0;
    haddr        = 32'h0;
    hwdata       = 32'h0;
    fire         = 4'h0;
    ce           = 1'h1;
    hold         = 16'h0019;
    err_count    = 0;
    n_compared   = 0;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'h1;
    t_regs;
    t_react(32'h03, B);
    t_react(32'h1F, B + 45);
    t_freeze;
    t_merge;
    t_prio;
    t_queue;
    t_nohnd;
    report_and_stop;
  end
endmodule : interrupt_event_queue_bench
